// [rtl/isvp_video_port.sv]
// isvp_video_port: parallel video output and setup register pins of the sensor.
// assumes i_clk well above the master clock pin; all pins are asynchronous.
//
// Operation
// [R1] the outside supplies a master clock at twice the pixel rate
// [R2] pixel clock output runs at half the master clock rate
// [R3] line-valid strobe is low during an active line, high otherwise; the code also holds it high for line periods stalled on an empty buffer
// [R4] frame-valid strobe is low during an active frame, high otherwise
// [R5] enable asserted: converter enabled and pixel words driven on the bus
// [R6] enable deasserted: every video data output is released to high impedance
// [R7] video bus is ten bits, bit 0 least significant, bit 9 most
// [R8] controller selects a setup register with a five-bit address, bit 0 lsb
// [R9] setup data lines are two-way: controller writes, device drives reads
// [R10] each setup register holds twelve bits over a twelve-bit bus
// [R11] active-low select and active-low write choose read or write
// [R12] one new pixel word per pixel clock period while line-valid is low
`default_nettype none
module isvp_video_port
   import isvp_pkg::*;
#(
   parameter int PIX_PER_LINE    = DEF_PIX_PER_LINE,
   parameter int LINES_PER_FRAME = DEF_LINES_PER_FRAME,
   parameter int HBLANK          = DEF_HBLANK,
   parameter int VBLANK          = DEF_VBLANK
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_reset_n,
   // pins from the capture controller, plus the setup data pins driven back to it
   input  wire logic                  i_master_clock_in,
   input  wire logic                  i_video_output_enable,
   input  wire logic [CFG_ADDR_W-1:0] i_cfg_addr,
   input  wire logic                  i_cfg_cs_n,
   input  wire logic                  i_cfg_wr_n,
   input  wire logic [CFG_DATA_W-1:0] i_cfg_data,
   output logic      [CFG_DATA_W-1:0] o_cfg_data,
   output logic                       o_cfg_data_oe_n,
   // pins to the capture controller
   output logic                       o_pixel_clock_out,
   output logic                       o_line_valid_n,
   output logic                       o_frame_valid_n,
   output logic      [VIDEO_W-1:0]    o_video_data,
   output logic                       o_video_data_oe_n,
   // converter side
   output logic                       o_adc_enable,
   input  wire logic [VIDEO_W-1:0]    i_adc_data,
   input  wire logic                  i_adc_valid,
   output logic                       o_adc_ready
);
   localparam int CW = $clog2(PIX_PER_LINE + HBLANK + VBLANK + 1);
   localparam int LW = $clog2(LINES_PER_FRAME + 1);
   localparam int SW = 2 + CFG_ADDR_W + CFG_DATA_W + 2;

   initial begin
      if (PIX_PER_LINE < 1 || LINES_PER_FRAME < 1 || HBLANK < 1 || VBLANK < 1) begin
         $error("isvp_video_port: geometry counts must be at least 1");
      end
   end

   localparam logic [CW-1:0] LAST_PIX = CW'(PIX_PER_LINE - 1);
   localparam logic [CW-1:0] LAST_HB  = CW'(HBLANK - 1);
   localparam logic [CW-1:0] LAST_VB  = CW'(VBLANK - 1);
   localparam logic [LW-1:0] LAST_LN  = LW'(LINES_PER_FRAME - 1);

   // ---------------- pin synchronisers ----------------
   logic [SW-1:0] sync_reg [SYNC_STAGES];
   wire  logic [SW-1:0] pins_async;
   wire  logic [SW-1:0] pins;

   assign pins_async = {i_master_clock_in, i_video_output_enable, i_cfg_addr,
                        i_cfg_data, i_cfg_cs_n, i_cfg_wr_n};

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sync_reg[0] <= '0;
      end else begin
         sync_reg[0] <= pins_async;
      end
   end

   genvar g;
   generate
      for (g = 1; g < SYNC_STAGES; g++) begin : g_sync
         always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               sync_reg[g] <= '0;
            end else begin
               sync_reg[g] <= sync_reg[g-1];
            end
         end
      end
   endgenerate

   assign pins = sync_reg[SYNC_STAGES-1];

   wire logic                  mclk_s  = pins[SW-1];
   wire logic                  ena_s   = pins[SW-2];
   wire logic [CFG_ADDR_W-1:0] addr_s  = pins[SW-3 -: CFG_ADDR_W];
   wire logic [CFG_DATA_W-1:0] wdata_s = pins[CFG_DATA_W+1:2];
   wire logic                  cs_n_s  = pins[1];
   wire logic                  wr_n_s  = pins[0];

   // ---------------- pixel clock ----------------
   logic mclk_d_reg;
   logic pclk_reg;
   wire  logic mclk_rise;
   wire  logic launch;

   assign mclk_rise = mclk_s && !mclk_d_reg;
   // words and strobes change as the pixel clock falls, receiver samples on its rise
   assign launch    = mclk_rise && pclk_reg;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         mclk_d_reg <= 1'b0;
         pclk_reg   <= 1'b0;
      end else begin
         mclk_d_reg <= mclk_s;
         if (mclk_rise) pclk_reg <= !pclk_reg;  // [R1] [R2]
      end
   end

   // ---------------- pixel buffer ----------------
   wire logic [VIDEO_W-1:0] buf_data;
   wire logic               buf_valid;
   wire logic               buf_pop;
   wire logic               buf_ready;
   wire logic               buf_push;
   wire logic               buf_full_next;

   // the registered ready promises room at the edge after it is seen,
   // so a word is taken exactly when valid meets a high ready
   assign buf_push      = i_adc_valid && o_adc_ready;
   assign buf_full_next = !buf_pop && (!buf_ready || (buf_valid && buf_push));

   isvp_pixel_buf #(
      .WIDTH (VIDEO_W),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_data    (i_adc_data),
      .i_valid   (buf_push),
      .o_ready   (buf_ready),
      .o_data    (buf_data),
      .o_valid   (buf_valid),
      .i_ready   (buf_pop)
   );

   // ---------------- frame sequencer ----------------
   isvp_state_t state_reg;
   isvp_state_t state_next;
   logic [CW-1:0] col_reg;
   logic [CW-1:0] col_next;
   logic [LW-1:0] row_reg;
   logic [LW-1:0] row_next;
   logic [VIDEO_W-1:0] vdata_reg;

   function automatic logic at_last(input logic [CW-1:0] c, input logic [CW-1:0] last);
      at_last = (c == last);
   endfunction

   // a line waits on an empty buffer rather than emit a stale word
   assign buf_pop = launch && (state_reg == ST_LINE) && buf_valid;  // [R12]

   always_comb begin
      state_next = state_reg;
      col_next   = col_reg;
      row_next   = row_reg;
      if (launch) begin
         case (state_reg)
            ST_IDLE: begin
               state_next = ST_LINE;
               col_next   = '0;
               row_next   = '0;
            end
            ST_LINE: begin
               if (buf_valid) begin
                  if (at_last(col_reg, LAST_PIX)) begin
                     state_next = ST_HBLANK;
                     col_next   = '0;
                  end else begin
                     col_next = col_reg + 1'b1;
                  end
               end
            end
            ST_HBLANK: begin
               if (!at_last(col_reg, LAST_HB)) begin
                  col_next = col_reg + 1'b1;
               end else if (row_reg == LAST_LN) begin
                  state_next = ST_VBLANK;
                  col_next   = '0;
               end else begin
                  state_next = ST_LINE;
                  col_next   = '0;
                  row_next   = row_reg + 1'b1;
               end
            end
            ST_VBLANK: begin
               if (at_last(col_reg, LAST_VB)) begin
                  state_next = ST_LINE;
                  col_next   = '0;
                  row_next   = '0;
               end else begin
                  col_next = col_reg + 1'b1;
               end
            end
            default: begin
               state_next = ST_IDLE;
               col_next   = '0;
               row_next   = '0;
            end
         endcase
      end
   end

   wire logic in_frame = (state_next == ST_LINE) || (state_next == ST_HBLANK);

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg       <= ST_IDLE;
         col_reg         <= '0;
         row_reg         <= '0;
         vdata_reg       <= VIDEO_RESET_VAL;
         o_line_valid_n  <= 1'b1;
         o_frame_valid_n <= 1'b1;
      end else begin
         state_reg <= state_next;
         col_reg   <= col_next;
         row_reg   <= row_next;
         if (buf_pop) vdata_reg <= buf_data;                  // [R7] [R12]
         if (launch) begin
            // low exactly for the period whose word was popped at this launch
            o_line_valid_n  <= !buf_pop;                      // [R3]
            o_frame_valid_n <= !in_frame;                     // [R4]
         end
      end
   end

   // ---------------- video output stage ----------------
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_pixel_clock_out <= 1'b0;
         o_adc_enable      <= 1'b0;
         o_adc_ready       <= 1'b0;
         o_video_data      <= VIDEO_RESET_VAL;
         o_video_data_oe_n <= 1'b1;
      end else begin
         o_pixel_clock_out <= pclk_reg;                       // [R2]
         o_adc_enable      <= ena_s;                          // [R5]
         o_adc_ready       <= ena_s && !buf_full_next;
         o_video_data      <= vdata_reg;                      // [R7]
         o_video_data_oe_n <= !ena_s;                         // [R5] [R6]
      end
   end

   // ---------------- setup registers ----------------
   logic [CFG_DATA_W-1:0] cfg_mem_reg [CFG_DEPTH];
   logic                  wr_n_d_reg;
   logic [CFG_ADDR_W-1:0] addr_d_reg;
   logic [CFG_DATA_W-1:0] wdata_d_reg;
   wire  logic            cfg_write;
   wire  logic            cfg_read;

   // write lands as the write strobe rises inside an active select
   assign cfg_write = !wr_n_d_reg && wr_n_s && !cs_n_s;        // [R11]
   assign cfg_read  = !cs_n_s && wr_n_s;                       // [R11]

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_n_d_reg      <= 1'b1;
         addr_d_reg      <= '0;
         wdata_d_reg     <= CFG_RESET_VAL;
         o_cfg_data      <= CFG_RESET_VAL;
         o_cfg_data_oe_n <= 1'b1;
         for (int k = 0; k < CFG_DEPTH; k++) begin
            cfg_mem_reg[k] <= CFG_RESET_VAL;
         end
      end else begin
         wr_n_d_reg  <= wr_n_s;
         addr_d_reg  <= addr_s;
         wdata_d_reg <= wdata_s;
         if (cfg_write) cfg_mem_reg[addr_d_reg] <= wdata_d_reg; // [R8] [R10]
         o_cfg_data      <= cfg_mem_reg[addr_s];                // [R8] [R10]
         o_cfg_data_oe_n <= !cfg_read;                          // [R9]
      end
   end
endmodule
`default_nettype wire

// [rtl/isvp_pkg.sv]
// isvp_pkg: shared widths, counts and state encodings of the video port.
// assumes nothing of its surroundings; imported by every isvp module.
`default_nettype none
package isvp_pkg;
   localparam int VIDEO_W     = 10;  // pixel word, bit 0 lsb
   localparam int CFG_ADDR_W  = 5;   // setup register address, bit 0 lsb
   localparam int CFG_DATA_W  = 12;  // setup register width
   localparam int CFG_DEPTH   = 32;  // registers reachable by a 5-bit address
   localparam int SYNC_STAGES = 2;   // flip-flops in every pin synchroniser
   localparam int BUF_DEPTH   = 2;   // entries of the pixel buffer

   // default frame geometry: pixels per line, lines per frame, blanking in pixel clock periods
   localparam int DEF_PIX_PER_LINE    = 1024;
   localparam int DEF_LINES_PER_FRAME = 1024;
   localparam int DEF_HBLANK          = 16;
   localparam int DEF_VBLANK          = 64;

   localparam logic [CFG_DATA_W-1:0] CFG_RESET_VAL = 12'h000;
   localparam logic [VIDEO_W-1:0]    VIDEO_RESET_VAL = 10'h000;

   // gray-coded along idle -> line -> hblank -> vblank
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_LINE   = 2'b01,
      ST_HBLANK = 2'b11,
      ST_VBLANK = 2'b10
   } isvp_state_t;
endpackage
`default_nettype wire

// [rtl/isvp_pixel_buf.sv]
// isvp_pixel_buf: small valid/ready fifo in the pixel path.
// assumes one clock for both sides; depth a power of two, at least two.
`default_nettype none
module isvp_pixel_buf
   import isvp_pkg::*;
#(
   parameter int WIDTH = VIDEO_W,
   parameter int DEPTH = BUF_DEPTH
) (
   input  wire logic             i_clk,
   input  wire logic             i_reset_n,
   input  wire logic [WIDTH-1:0] i_data,
   input  wire logic             i_valid,
   output logic                  o_ready,
   output logic [WIDTH-1:0]      o_data,
   output logic                  o_valid,
   input  wire logic             i_ready
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("isvp_pixel_buf: DEPTH must be a power of two, at least 2");
      end
   end

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0]      wr_ptr_reg;
   logic [AW:0]      rd_ptr_reg;
   wire  logic       full;
   wire  logic       empty;
   wire  logic       push;
   wire  logic       pop;

   assign full    = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                    (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign empty   = (wr_ptr_reg == rd_ptr_reg);
   assign o_ready = !full;
   assign o_valid = !empty;
   assign o_data  = mem_reg[rd_ptr_reg[AW-1:0]];
   assign push    = i_valid && !full;
   assign pop     = i_ready && !empty;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (push) mem_reg[wr_ptr_reg[AW-1:0]] <= i_data;
   end
endmodule
`default_nettype wire

// [bench/isvp_video_port_checker.sv]
// isvp_video_port_checker: port-level assertions of the video port.
// assumes it is bound into every isvp_video_port and sees only its ports.
`default_nettype none
module isvp_video_port_checker
   import isvp_pkg::*;
(
   input wire logic               i_clk,
   input wire logic               i_reset_n,
   input wire logic               i_master_clock_in,
   input wire logic               i_cfg_cs_n,
   input wire logic               i_cfg_wr_n,
   input wire logic               o_cfg_data_oe_n,
   input wire logic               o_pixel_clock_out,
   input wire logic               o_line_valid_n,
   input wire logic               o_frame_valid_n,
   input wire logic [VIDEO_W-1:0] o_video_data,
   input wire logic               o_video_data_oe_n,
   input wire logic               o_adc_enable
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   a_pclk_follows_master: assert property (
      $rose(i_master_clock_in) |-> ##4 $changed(o_pixel_clock_out)) else $error("pclk late");
   a_oe_tracks_enable: assert property (
      o_video_data_oe_n == !o_adc_enable) else $error("bus drive and converter disagree");
   a_line_in_frame: assert property (
      !o_line_valid_n |-> !o_frame_valid_n) else $error("line strobe outside frame");
   a_line_at_fall: assert property (
      $changed(o_line_valid_n) |=> $fell(o_pixel_clock_out)) else $error("line strobe skew");
   a_frame_at_fall: assert property (
      $changed(o_frame_valid_n) |=> $fell(o_pixel_clock_out)) else $error("frame strobe skew");
   a_word_after_fall: assert property (
      $changed(o_video_data) |-> $fell(o_pixel_clock_out))
      else $error("pixel word off its period");
   a_cfg_read_drive: assert property (
      (!i_cfg_cs_n && i_cfg_wr_n) [*4] |-> !o_cfg_data_oe_n) else $error("read not driven");
   a_cfg_release: assert property (
      (i_cfg_cs_n || !i_cfg_wr_n) [*4] |-> o_cfg_data_oe_n) else $error("setup pins held");
   c_line: cover property (!o_line_valid_n);
   c_read: cover property (!o_cfg_data_oe_n);
   c_stall: cover property (!o_frame_valid_n && o_line_valid_n && !o_pixel_clock_out);
endmodule
bind isvp_video_port isvp_video_port_checker u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
   .i_master_clock_in(i_master_clock_in), .i_cfg_cs_n(i_cfg_cs_n), .i_cfg_wr_n(i_cfg_wr_n),
   .o_cfg_data_oe_n(o_cfg_data_oe_n), .o_pixel_clock_out(o_pixel_clock_out),
   .o_line_valid_n(o_line_valid_n), .o_frame_valid_n(o_frame_valid_n),
   .o_video_data(o_video_data), .o_video_data_oe_n(o_video_data_oe_n),
   .o_adc_enable(o_adc_enable));
`default_nettype wire

// [bench/isvp_grabber_model.sv]
// isvp_grabber_model: capture controller on the far side of the video port.
// assumes an 80 ns oscillator and capture at the pixel clock rise.
`default_nettype none
module isvp_grabber_model
   import isvp_pkg::*;
(
   input  wire logic               i_run,
   input  wire logic               i_pclk,
   input  wire logic               i_line_n,
   input  wire logic               i_frame_n,
   input  wire logic [VIDEO_W-1:0] i_data,
   input  wire logic               i_oe_n,
   output logic                    o_mclk
);
   timeunit 1ns;
   timeprecision 100ps;
   wire  [VIDEO_W-1:0] bus = i_oe_n ? 10'hzzz : i_data;
   logic [VIDEO_W-1:0] words[$];
   int                 base = 0;
   int                 last_cnt = 0;
   int                 frames = 0;
   logic               frame_d = 1'b1;
   // free-running oscillator at twice the pixel rate once started
   initial begin
      o_mclk = 1'b0;
      wait (i_run);
      forever #40 o_mclk = ~o_mclk;
   end
   always @(posedge i_pclk) begin
      if (!i_line_n)
         words.push_back(bus);
      if (i_frame_n && !frame_d) begin
         last_cnt = words.size() - base;
         base = words.size();
         frames++;
      end
      frame_d = i_frame_n;
   end
endmodule
`default_nettype wire

// [bench/tb_isvp_video_port.sv]
// tb_isvp_video_port: self-checking bench of the video port.
// assumes the grabber model and the bound port checker are compiled first.
`default_nettype none
module tb_isvp_video_port;
   timeunit 1ns;
   timeprecision 100ps;
   import isvp_pkg::*;
   localparam int PPL = 4;
   localparam int LPF = 3;
   logic                  clk, rst_n, run, en, cs_n, wr_n, drv, vld;
   logic [CFG_ADDR_W-1:0] addr;
   logic [CFG_DATA_W-1:0] cfg_w, cfg_o;
   logic [VIDEO_W-1:0]    adc, vid;
   logic                  mclk, cfg_oe_n, pclk, lv_n, fv_n, vid_oe_n, adc_en, adc_rdy;
   int                    error_cnt = 0;
   int                    checked = 0;
   // released setup pins show the inverse of the last driven word
   wire  [CFG_DATA_W-1:0] cfg_bus = !cfg_oe_n ? cfg_o : (drv ? cfg_w : ~cfg_w);
   isvp_video_port #(.PIX_PER_LINE(PPL), .LINES_PER_FRAME(LPF), .HBLANK(2), .VBLANK(2)) dut (
      .i_clk(clk), .i_reset_n(rst_n), .i_master_clock_in(mclk), .i_video_output_enable(en),
      .i_cfg_addr(addr), .i_cfg_cs_n(cs_n), .i_cfg_wr_n(wr_n), .i_cfg_data(cfg_bus),
      .o_cfg_data(cfg_o), .o_cfg_data_oe_n(cfg_oe_n), .o_pixel_clock_out(pclk),
      .o_line_valid_n(lv_n), .o_frame_valid_n(fv_n), .o_video_data(vid),
      .o_video_data_oe_n(vid_oe_n), .o_adc_enable(adc_en), .i_adc_data(adc),
      .i_adc_valid(vld), .o_adc_ready(adc_rdy));
   isvp_grabber_model u_grab (.i_run(run), .i_pclk(pclk), .i_line_n(lv_n), .i_frame_n(fv_n),
      .i_data(vid), .i_oe_n(vid_oe_n), .o_mclk(mclk));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, m, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic give_up(input string m);
      chk(1'b0, 1'b1, m);
      complete_run();
   endtask
   task automatic cfg_write(input logic [4:0] a, input logic [11:0] d);
      @(negedge clk);
      {cs_n, wr_n, drv, addr, cfg_w} = {3'b001, a, d};
      repeat (4) @(negedge clk);
      chk(cfg_oe_n, 1'b1, "setup pins driven in write");
      wr_n = 1'b1;
      repeat (3) @(negedge clk);
      {cs_n, drv} = 2'b10;
      repeat (2) @(negedge clk);
   endtask
   task automatic cfg_read(input logic [4:0] a, input logic [11:0] d);
      @(negedge clk);
      {cs_n, wr_n, addr} = {2'b01, a};
      repeat (4) @(negedge clk);
      chk(cfg_oe_n, 1'b0, "read not driven");
      chk(cfg_bus, d, "setup read data");
      cs_n = 1'b1;
   endtask
   task automatic feed(input logic [VIDEO_W-1:0] w);
      @(negedge clk);
      {adc, vld} = {w, 1'b1};
      // ready seen between edges means the next rising edge takes the word
      for (int i = 0; adc_rdy !== 1'b1; i++) begin
         if (i == 200)
            give_up("converter word not taken");
         @(negedge clk);
      end
      @(negedge clk);
      vld = 1'b0;
      repeat (3) @(negedge clk);
   endtask
   task automatic t_cfg();
      cfg_read(5'h1f, CFG_RESET_VAL);
      for (int a = 0; a < CFG_DEPTH; a++)
         cfg_write(5'(a), {5'(a), ~5'(a), 2'b10});
      for (int a = 0; a < CFG_DEPTH; a++)
         cfg_read(5'(a), {5'(a), ~5'(a), 2'b10});
   endtask
   // fill the buffer before the master clock runs, then let it drain and stall
   task automatic t_fill_stall();
      feed(10'h3ff);
      feed(10'h001);
      chk(adc_rdy, 1'b0, "full buffer still ready");
      run = 1'b1;
      for (int i = 0; u_grab.words.size() < 2; i++) begin
         if (i == 2000)
            give_up("pixel words missing");
         @(negedge clk);
      end
      repeat (40) @(negedge clk);
      chk({lv_n, fv_n}, 2'b10, "empty buffer keeps line strobe");
      chk(u_grab.words.size(), 2, "words during stall");
   endtask
   task automatic t_frame();
      for (int w = 2; w < 28; w++)
         feed(10'(w));
      chk(u_grab.frames >= 2, 1'b1, "frames not completed");
      chk(u_grab.last_cnt, PPL * LPF, "words in one frame");
      for (int i = 0; i < u_grab.words.size(); i++)
         chk(u_grab.words[i], (i == 0) ? 32'h0000_03ff : 32'(i), "pixel order");
   endtask
   task automatic t_enable();
      en = 1'b0;
      repeat (6) @(negedge clk);
      chk({vid_oe_n, adc_en, adc_rdy}, 3'b100, "disabled port active");
      chk(u_grab.bus, 10'hzzz, "video bus not released");
      en = 1'b1;
      repeat (6) @(negedge clk);
      chk({vid_oe_n, adc_en}, 2'b01, "enabled port idle");
   endtask
   initial begin
      {rst_n, run, en, cs_n, wr_n, drv, vld} = 7'b0011100;
      addr = 5'h00;
      cfg_w = 12'h000;
      adc = 10'h000;
      repeat (5) @(negedge clk);
      chk({pclk, lv_n, fv_n, vid_oe_n, cfg_oe_n, adc_en}, 6'b011110, "reset levels");
      @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_cfg();
      t_fill_stall();
      t_frame();
      t_enable();
      complete_run();
   end
endmodule
`default_nettype wire
